/* core/edge_sync.sv */
// Three-stage pin synchroniser with a rising-edge pulse
`timescale 1ns/1ps
module edge_sync (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic pin,
	output logic      rise
);
	// All synchroniser state
	typedef struct packed {
		logic s1;     // First stage, read only by s2
		logic s2;     // Second stage
		logic s3;     // Third stage
		logic level;  // Accepted level
		logic rise;   // One-cycle rising pulse
	} sync_t;

	sync_t state;
	sync_t next_state;

	// Level changes only once stages two and three agree
	always_comb begin
		next_state = state;
		next_state.s1 = pin;
		next_state.s2 = state.s1;
		next_state.s3 = state.s2;
		next_state.rise = 1'b0;
		if (state.s2 == state.s3) begin
			next_state.level = state.s3;
			next_state.rise = state.s3 & ~state.level;
		end
	end

	// State register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rise = state.rise;

endmodule

/* core/timer_pkg.sv */
// Shared constants for the event-capture timer
package timer_pkg;

	// Register byte addresses on the APB
	localparam logic [31:0] ADDR_RELOAD  = 32'hFFFF0380;
	localparam logic [31:0] ADDR_COUNT   = 32'hFFFF0384;
	localparam logic [31:0] ADDR_CONTROL = 32'hFFFF0388;
	localparam logic [31:0] ADDR_CLEAR   = 32'hFFFF038C;
	localparam logic [31:0] ADDR_CAPTURE = 32'hFFFF0390;
	localparam logic [31:0] ADDR_STATUS  = 32'hFFFF0394;
	localparam logic [31:0] ADDR_MASK    = 32'hFFFF0398;

	// Control field positions
	localparam int PRESCALE_LSB = 0;
	localparam int PRESCALE_W   = 4;
	localparam int PERIODIC_BIT = 6;
	localparam int ENABLE_BIT   = 7;
	localparam int DIR_BIT      = 8;
	localparam int CLKSEL_LSB   = 9;
	localparam int CLKSEL_W     = 2;
	localparam int CAPSEL_LSB   = 12;
	localparam int CAPSEL_W     = 5;
	localparam int CAPEN_BIT    = 17;

	// Writable control bits; the rest stay zero
	localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0003F7CF;

	// Clock source codes
	localparam logic [1:0] SRC_LOW_POWER   = 2'h0;
	localparam logic [1:0] SRC_CORE_DIV    = 2'h1;
	localparam logic [1:0] SRC_CORE_FULL   = 2'h2;

	// Interrupt status layout
	localparam int IRQ_WRAP    = 0;
	localparam int IRQ_CAPTURE = 1;
	localparam int IRQ_W       = 2;

	// Values after reset
	localparam logic [15:0] RELOAD_RESET  = 16'h0000;
	localparam logic [15:0] COUNT_RESET   = 16'hFFFF;
	localparam logic [15:0] CAPTURE_RESET = 16'h0000;
	localparam logic [31:0] CONTROL_RESET = 32'h00000000;
	localparam logic [1:0]  STATUS_RESET  = 2'h0;
	localparam logic [1:0]  MASK_RESET    = 2'h0;

	// Counter extremes
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_MIN = 16'h0000;

endpackage

/* core/timer_with_event_capture.sv */
// 16-bit up/down timer with prescaler, event capture and APB registers
//
// Function
// - Counter direction follows control bit 8
// - Counts only while enable bit 7 set
// - Bit 6 selects periodic, else free-running
// - Bits 10:9 choose the source clock
// - Bits 3:0 set prescaler divide ratio
// - Selected event edge copies count to capture
// - Capture works only while bit 17 set
// - Bits 16:12 pick one of 32 events
// - Reload register is read/write, resets zero
// - Any write to clear register clears interrupt; the code clears only the wrap flag
// - Value register reads live count, resets FFFF
// - Capture read-only, resets zero, writes ignored
// - Control is 32 bits, resets to zero
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module timer_with_event_capture #(
	parameter int PRESCALE_MAX_W = 15,  // Widest prescale stage
	parameter int CORE_DIV_W     = 7,   // Widest core divider stage
	parameter int EVENT_COUNT    = 32   // Capture event sources
) (
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	// APB slave port
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Timer source clock pins
	input  wire logic                   lowPowerClk,
	input  wire logic                   coreClk,
	input  wire logic [2:0]             coreClockDivider,
	// Interrupt sources watched for capture
	input  wire logic [EVENT_COUNT-1:0] eventSources,
	// Timer interrupt
	output logic                        irq
);
	import timer_pkg::*;

	// Whole register state of the timer
	// One struct keeps the reset and the update of every field together
	typedef struct packed {
		logic [15:0]               reload;     // Load value
		logic [15:0]               count;      // Live counter
		logic [15:0]               capture;    // Captured count
		logic [31:0]               control;    // Configuration
		logic [IRQ_W-1:0]          status;     // Sticky events
		logic [IRQ_W-1:0]          mask;       // Interrupt enables
		logic [31:0]               readData;   // Read data for access phase
		logic [PRESCALE_MAX_W-1:0] prescale;   // Prescale counter
		logic [CORE_DIV_W-1:0]     coreDiv;    // Core clock divider counter
		logic [EVENT_COUNT-1:0]    lastEvents; // Event levels last cycle
		logic                      irqLine;    // Registered interrupt
	} timer_t;

	timer_t state;
	timer_t next_state;

	// Synchronised source edges, one-cycle pulses
	logic lowPowerRise;  // Oscillator rising edge, system domain
	logic coreRise;      // Core clock rising edge, system domain

	// Oscillator pin crossing
	// Both source pins are asynchronous; only their rising edges are used
	edge_sync lowPowerSync (
		.clock (clock),
		.rst_b (rst_b),
		.pin   (lowPowerClk),
		.rise  (lowPowerRise)
	);

	// Core clock pin crossing
	// Same three-stage crossing as the oscillator pin
	edge_sync coreSync (
		.clock (clock),
		.rst_b (rst_b),
		.pin   (coreClk),
		.rise  (coreRise)
	);

	// Control fields
	// Decoded once so that every process reads the same names
	logic                  periodicMode;
	logic                  timerEnable;
	logic                  countDirection;
	logic [CLKSEL_W-1:0]   sourceClockSelect;
	logic [PRESCALE_W-1:0] prescaleSelect;
	logic [CAPSEL_W-1:0]   captureEventSelect;
	logic                  captureEnable;

	// Field extraction
	// Reserved bits are never stored, so they need no decode
	always_comb begin
		periodicMode       = state.control[PERIODIC_BIT];
		timerEnable        = state.control[ENABLE_BIT];
		countDirection     = state.control[DIR_BIT];
		sourceClockSelect  = state.control[CLKSEL_LSB +: CLKSEL_W];
		prescaleSelect     = state.control[PRESCALE_LSB +: PRESCALE_W];
		captureEventSelect = state.control[CAPSEL_LSB +: CAPSEL_W];
		captureEnable      = state.control[CAPEN_BIT];
	end

	// Bus decode signals
	// Taken from the bus inputs of the current cycle; events come from the counter and capture logic
	logic             setupPhase;  // First cycle of a transfer
	logic             writeTaken;  // Write takes effect this edge
	logic             hit;         // Address is mapped
	logic [IRQ_W-1:0] clearBits;   // Status bits software clears
	logic [IRQ_W-1:0] events;      // Status bits hardware sets

	// Clocking chain signals
	// Ticks are one-cycle pulses in the system clock domain
	logic                      coreDivTick;  // Divided core clock tick
	logic                      sourceTick;   // Selected source tick
	logic                      countTick;    // Counter step
	logic [CORE_DIV_W-1:0]     coreMask;     // Core divider wrap mask
	logic [PRESCALE_MAX_W-1:0] prescaleMask; // Prescaler wrap mask
	logic [EVENT_COUNT-1:0]    eventRise;    // Event first assertions

	// APB phase decode; the slave never inserts wait states
	always_comb begin
		setupPhase = psel & ~penable;
		writeTaken = psel & penable & pwrite;
	end

	// Address decode; the full address must match one register word
	// Registers sit on aligned words, so a partial match never hits
	always_comb begin
		case (paddr)
			ADDR_RELOAD, ADDR_COUNT, ADDR_CONTROL, ADDR_CLEAR,
			ADDR_CAPTURE, ADDR_STATUS, ADDR_MASK: begin
				hit = 1'b1;  // Mapped word
			end
			default: begin
				hit = 1'b0;  // Unmapped, answered with an error
			end
		endcase
	end

	// Core divider tick: one in every two to the divider code rises
	// The divider runs while the timer is disabled too, so the divided
	// source keeps a steady phase across enable and disable
	always_comb begin
		coreMask    = CORE_DIV_W'((8'h01 << coreClockDivider) - 8'h01);
		coreDivTick = coreRise && ((state.coreDiv & coreMask) == coreMask);
	end

	// Source clock choice; code 11 gives no ticks and so freezes the count
	always_comb begin
		case (sourceClockSelect)
			SRC_LOW_POWER: begin
				sourceTick = lowPowerRise;  // Low-power oscillator
			end
			SRC_CORE_DIV: begin
				sourceTick = coreDivTick;  // Divided core clock
			end
			SRC_CORE_FULL: begin
				sourceTick = coreRise;  // Undivided core clock
			end
			default: begin
				sourceTick = 1'b0;
			end
		endcase
	end

	// Per-source first-assertion detectors for event capture
	// A source that stays high captures once; it must fall and rise again
	for (genvar gi = 0; gi < EVENT_COUNT; gi++) begin
		assign eventRise[gi] = eventSources[gi] & ~state.lastEvents[gi];
	end

	// Next-state logic
	// Sections run in priority order: a bus write further down
	// overrides a counter step of the same cycle
	always_comb begin
		// Defaults: every field holds and no pulse is raised
		next_state = state;
		clearBits  = '0;
		events     = '0;
		countTick  = 1'b0;

		// Core divider counts every core rise and restarts at its tick
		if (coreRise) begin
			next_state.coreDiv = coreDivTick ? '0 : state.coreDiv + 1'b1;
		end

		// Prescaler divides by two to the select code
		// Only the masked bits are compared, so lowering the code takes
		// effect on the next source tick without waiting for a wrap
		prescaleMask = PRESCALE_MAX_W'((16'h0001 << prescaleSelect) - 16'h0001);
		if (!timerEnable) begin
			// Held clear while disabled so that enabling starts a full period
			next_state.prescale = '0;
		end else if (sourceTick) begin
			if ((state.prescale & prescaleMask) == prescaleMask) begin
				next_state.prescale = '0;
				countTick = 1'b1;
			end else begin
				next_state.prescale = state.prescale + 1'b1;
			end
		end

		// Counter step and wrap handling
		// A wrap flags the event in either mode; periodic mode restarts from
		// the reload value, free-running mode rolls over the full range
		if (countTick) begin
			if (countDirection) begin
				// Overflow past the top of the range
				if (state.count == COUNT_MAX) begin
					events[IRQ_WRAP] = 1'b1;
					next_state.count = periodicMode ? state.reload : COUNT_MIN;
				end else begin
					next_state.count = state.count + 16'h0001;
				end
			end else begin
				// Underflow below the bottom of the range
				if (state.count == COUNT_MIN) begin
					events[IRQ_WRAP] = 1'b1;
					next_state.count = periodicMode ? state.reload : COUNT_MAX;
				end else begin
					next_state.count = state.count - 16'h0001;
				end
			end
		end

		// Event capture on first assertion of the selected source
		// The capture takes the count from before this cycle's step, and
		// the counter keeps running undisturbed
		// Capture also raises its own status flag
		next_state.lastEvents = eventSources;
		if (captureEnable && eventRise[captureEventSelect]) begin
			next_state.capture = state.count;
			events[IRQ_CAPTURE] = 1'b1;
		end

		// Register writes
		// Writes take effect at the edge that ends the access phase
		if (writeTaken) begin
			case (paddr)
				ADDR_RELOAD: begin
					// Loading also restarts the count and the prescaler
					next_state.reload = pwdata[15:0];
					next_state.count  = pwdata[15:0];
					next_state.prescale = '0;
				end
				ADDR_CONTROL: begin
					// Reserved bits are dropped and read back as zero
					next_state.control = pwdata & CONTROL_WRITE_MASK;
				end
				ADDR_CLEAR: begin
					// The written data is ignored
					clearBits[IRQ_WRAP] = 1'b1;
				end
				ADDR_STATUS: begin
					// Write one to clear
					clearBits = pwdata[IRQ_W-1:0];
				end
				ADDR_MASK: begin
					// One enable per status bit
					next_state.mask = pwdata[IRQ_W-1:0];
				end
				default: begin
					// Count and capture registers ignore writes
					next_state.control = state.control;
				end
			endcase
		end

		// Sticky status; a new event wins over a clear
		// The clear register drops only the wrap flag
		next_state.status = (state.status & ~clearBits) | events;

		// Read data staged in the setup cycle
		// Count, capture and status words include this edge's update, so the
		// value read is the one standing when the access phase begins
		if (setupPhase) begin
			case (paddr)
				ADDR_RELOAD: begin
					next_state.readData = {16'h0000, state.reload};
				end
				ADDR_COUNT: begin
					next_state.readData = {16'h0000, next_state.count};
				end
				ADDR_CONTROL: begin
					next_state.readData = state.control;
				end
				ADDR_CAPTURE: begin
					next_state.readData = {16'h0000, next_state.capture};
				end
				ADDR_STATUS: begin
					next_state.readData = {30'h0, next_state.status};
				end
				ADDR_MASK: begin
					next_state.readData = {30'h0, state.mask};
				end
				default: begin
					// Clear register and unmapped words read as zero
					next_state.readData = 32'h00000000;
				end
			endcase
		end

		// Level interrupt from unmasked flags
		// Registered, so the pin cannot glitch while status bits settle
		next_state.irqLine = |(next_state.status & next_state.mask);
	end

	// State register
	// All fields reset to constants; the pin stages reset in their own
	// module, so a tick cannot arrive during the first cycles after reset
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state.reload     <= RELOAD_RESET;
			state.count      <= COUNT_RESET;
			state.capture    <= CAPTURE_RESET;
			state.control    <= CONTROL_RESET;
			state.status     <= STATUS_RESET;
			state.mask       <= MASK_RESET;
			state.readData   <= 32'h00000000;
			state.prescale   <= '0;
			state.coreDiv    <= '0;
			state.lastEvents <= '0;
			state.irqLine    <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Read data from the staging register
	assign prdata  = state.readData;

	// Every access completes in one cycle
	assign pready  = 1'b1;

	// Unmapped accesses report an error and change nothing
	assign pslverr = psel & penable & ~hit;

	// Interrupt line from its register
	assign irq     = state.irqLine;

endmodule

/* sim/tb_timer_with_event_capture.sv */
// Self-checking bench for the event-capture timer
`timescale 1ns/1ps
module tb_timer_with_event_capture;
	import timer_pkg::*;
	logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic        pready, pslverr, irq, err, lowPowerClk = 0, coreClk = 0;
	logic [2:0]  coreClockDivider = 0;
	logic [31:0] eventSources = 0;
	int          bad_count = 0, checks = 0, s, v, c;
	int          relM = 0, cntM = 32'hFFFF, ctlM = 0, capM = 0, staM = 0, mskM = 0;
	int          st[4] = '{4, 2, 4, 0}; // Steps per source code for four ticks
	always #2 clock = ~clock;
	timer_with_event_capture uut (.clock(clock), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lowPowerClk(lowPowerClk),
		.coreClk(coreClk), .coreClockDivider(coreClockDivider),
		.eventSources(eventSources), .irq(irq));
	// Compare and count
	task automatic chk(string n, logic [31:0] e, logic [31:0] seen);
		checks++;
		if (seen !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, seen);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	// Write and update the model
	task automatic wr(logic [31:0] a, logic [31:0] d);
		apb(1'b1, a, d);
		chk("write error", 32'h0, {31'h0, err});
		case (a)
			ADDR_RELOAD: begin
				relM = d[15:0];
				cntM = d[15:0];
			end
			ADDR_CONTROL: ctlM = d & CONTROL_WRITE_MASK;
			ADDR_CLEAR: staM &= 2;
			ADDR_STATUS: staM &= ~d;
			ADDR_MASK: mskM = d & 3;
			default: ;
		endcase
	endtask
	// Read, compare data and interrupt line
	task automatic rdc(logic [31:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read data", e, rd);
		chk("irq", {31'h0, (staM & mskM) != 0}, {31'h0, irq});
	endtask
	// Model of counter steps
	task automatic stepM(int n);
		repeat (n) begin
			if (cntM == (ctlM[DIR_BIT] ? 32'hFFFF : 32'h0)) begin
				staM |= 1;
				cntM = ctlM[PERIODIC_BIT] ? relM : (ctlM[DIR_BIT] ? 32'h0 : 32'hFFFF);
			end else
				cntM = ctlM[DIR_BIT] ? cntM + 1 : cntM - 1;
		end
	endtask
	// Source clock pulses, then sync settling
	task automatic tick(int n, logic low);
		repeat (n) begin
			lowPowerClk <= low;
			coreClk <= !low;
			repeat (4) @(posedge clock);
			lowPowerClk <= 1'b0;
			coreClk <= 1'b0;
			repeat (4) @(posedge clock);
		end
		repeat (8) @(posedge clock);
	endtask
	task automatic run(logic [31:0] ctl, int n, logic low, int steps);
		wr(ADDR_CONTROL, ctl);
		tick(n, low);
		stepM(steps);
		rdc(ADDR_COUNT, cntM);
		rdc(ADDR_STATUS, staM);
	endtask
	// Event pulse on one source
	task automatic ev(int x);
		eventSources[x] <= 1'b1;
		repeat (3) @(posedge clock);
		eventSources[x] <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#200000;
		bad_count++;
		close_out();
	end
	// Main sequence
	initial begin
		v = $urandom(72);
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rdc(ADDR_RELOAD, 32'h0);
		rdc(ADDR_COUNT, 32'hFFFF);
		rdc(ADDR_CONTROL, 32'h0);
		rdc(ADDR_CAPTURE, 32'h0);
		wr(ADDR_CONTROL, 32'hFFFFFF7F);
		rdc(ADDR_CONTROL, ctlM);
		wr(ADDR_COUNT, 32'h1234);
		wr(ADDR_CAPTURE, 32'h1234);
		rdc(ADDR_COUNT, cntM);
		rdc(ADDR_CAPTURE, capM);
		apb(1'b0, 32'hFFFF03A0, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		wr(ADDR_MASK, 32'h3);
		wr(ADDR_RELOAD, 32'hFFFE);
		run(32'h580, 3, 1'b0, 3);
		wr(ADDR_CLEAR, 32'hA5);
		rdc(ADDR_STATUS, staM);
		run(32'h500, 2, 1'b0, 0);
		wr(ADDR_RELOAD, 32'h2);
		run(32'h4C0, 4, 1'b0, 4);
		coreClockDivider <= 3'h1;
		for (s = 0; s < 4; s++) begin
			wr(ADDR_CONTROL, 32'h0);
			wr(ADDR_RELOAD, $urandom);
			run(32'h80 | (s << CLKSEL_LSB), 4, s == 0, st[s]);
		end
		for (c = 0; c < 12; c += 4) begin
			wr(ADDR_CONTROL, 32'h0);
			wr(ADDR_RELOAD, $urandom);
			run(32'h580 | c, 2 << c, 1'b0, 2);
		end
		wr(ADDR_STATUS, 32'h3);
		s = $urandom_range(31);
		wr(ADDR_RELOAD, $urandom);
		wr(ADDR_CONTROL, 32'h20680 | (s << CAPSEL_LSB));
		ev((s + 1) % 32);
		rdc(ADDR_CAPTURE, capM);
		ev(s);
		capM = cntM;
		staM |= 2;
		rdc(ADDR_CAPTURE, capM);
		rdc(ADDR_STATUS, staM);
		wr(ADDR_CONTROL, 32'h00680 | (s << CAPSEL_LSB));
		wr(ADDR_RELOAD, cntM + 1);
		ev(s);
		rdc(ADDR_CAPTURE, capM);
		close_out();
	end
endmodule

/* sim/timer_with_event_capture_assertions.sv */
// Port-level checker for the event-capture timer
`timescale 1ns/1ps
module timer_with_event_capture_assertions
	import timer_pkg::*;
#(
	parameter int EVENT_COUNT = 32
) (
	input wire logic                   clock,
	input wire logic                   rst_b,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [31:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   lowPowerClk,
	input wire logic                   coreClk,
	input wire logic [2:0]             coreClockDivider,
	input wire logic [EVENT_COUNT-1:0] eventSources,
	input wire logic                   irq
);
	logic mapped; // Address hits a register word
	logic rdAcc;  // Read access phase
	assign mapped = paddr >= ADDR_RELOAD && paddr <= ADDR_MASK && paddr[1:0] == 2'h0;
	assign rdAcc = psel && penable && !pwrite;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_ready_high: assert property (pready) else $error("pready low");
	a_unmapped_error: assert property (psel && penable && !mapped |-> pslverr)
		else $error("no error on unmapped access");
	a_mapped_quiet: assert property (psel && penable && mapped |-> !pslverr)
		else $error("error on mapped access");
	a_ctrl_reserved: assert property (
		rdAcc && paddr == ADDR_CONTROL |-> (prdata & ~CONTROL_WRITE_MASK) == 32'h0)
		else $error("reserved control bits set");
	a_upper_zero: assert property (
		rdAcc && (paddr == ADDR_RELOAD || paddr == ADDR_COUNT || paddr == ADDR_CAPTURE)
		|-> prdata[31:16] == 16'h0) else $error("upper half not zero");
	a_clear_reads_zero: assert property (rdAcc && paddr == ADDR_CLEAR |-> prdata == 32'h0)
		else $error("clear register read not zero");
	a_read_hold: assert property (psel && penable ##1 !psel |-> $stable(prdata))
		else $error("read data moved while idle");
	a_irq_after_reset: assert property ($rose(rst_b) |-> !irq)
		else $error("irq high after reset");
	cover property (psel && penable && !mapped);
	cover property ($rose(irq));
	cover property (rdAcc && paddr == ADDR_CAPTURE && prdata != 32'h0);
endmodule
bind timer_with_event_capture timer_with_event_capture_assertions #(
	.EVENT_COUNT(EVENT_COUNT)) chk (.clock(clock), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .lowPowerClk(lowPowerClk), .coreClk(coreClk),
	.coreClockDivider(coreClockDivider), .eventSources(eventSources), .irq(irq));
